// ==== inc/spdc_params.svh ====
// Constants for the serial port default configuration block.
// Assumes a 100 MHz clock and an AHB-Lite slave with 32-bit words.
`ifndef SPDC_PARAMS_SVH
`define SPDC_PARAMS_SVH
`define SPDC_ADDR_MODE      8'h00
`define SPDC_ADDR_CMD       8'h04
`define SPDC_ADDR_CTRL      8'h08
`define SPDC_ADDR_SWITCH    8'h0C
`define SPDC_ADDR_STATUS    8'h10
`define SPDC_CMD_RESET      8'h05
`define SPDC_CTRL_IRESET    5
`define SPDC_CLK_HZ         100000000
`define SPDC_FACT_ZERO      2'h0
`define SPDC_FACT_X1        2'h1
`define SPDC_FACT_X16       2'h2
`define SPDC_FACT_X64       2'h3
`define SPDC_SEL_MIN        4'h2
`define SPDC_DEF_MODE       8'hCF
`define SPDC_DEF_RATE_POS   4'h7
`define SPDC_DEF_SEL_STD    4'hA
`define SPDC_DEF_SEL_OPT    4'hB
`define SPDC_HTRANS_NONSEQ  2'h2
`define SPDC_HSIZE_WORD     3'h2
`endif

// ==== inc/spdc_pkg.sv ====
// Types for the serial port default configuration block.
// Assumes spdc_params.svh is on the include path.
package spdc_pkg;
	typedef struct packed {
		logic [1:0] stop_bits;
		logic       parity_even;
		logic       parity_en;
		logic [1:0] char_len;
		logic [1:0] rate_factor;
	} spdc_mode_type;

	typedef struct packed {
		logic       ext_tx_clk;
		logic       ext_rx_clk;
		logic       cts_dev;
		logic       cur_loop;
		logic [3:0] rate_pos;
		logic [3:0] sel_code;
	} spdc_sw_type;

	typedef struct packed {
		logic       tx_clk;
		logic       rx_clk;
		logic       cts;
		logic       rts_en;
		logic       sel_ok;
	} spdc_link_type;

	typedef enum logic [2:0] {
		SPDC_IN_RESET = 3'b001,
		SPDC_RUN      = 3'b010,
		SPDC_IRESET   = 3'b100
	} spdc_state_type;
endpackage : spdc_pkg

// ==== logic/spdc_top.sv ====
// Default configuration logic of a serial interface card.
// Assumes a single AHB-Lite master and synchronous switch inputs.
`include "spdc_params.svh"
module spdc_top
	import spdc_pkg::*;
#(
	parameter int CLK_HZ = `SPDC_CLK_HZ
) (
	// Clock, reset, enable
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          ce_i,
	// AHB-Lite slave
	input  wire logic          hsel_i,
	input  wire logic [31:0]   haddr_i,
	input  wire logic [1:0]    htrans_i,
	input  wire logic          hwrite_i,
	input  wire logic [2:0]    hsize_i,
	input  wire logic [31:0]   hwdata_i,
	input  wire logic          hready_i,
	output logic      [31:0]   hrdata_o,
	output logic               hreadyout_o,
	output logic               hresp_o,
	// Switches, high when open
	input  wire logic [7:0]    mode_sw_i,
	input  spdc_sw_type        cfg_sw_i,
	// Cable side
	input  wire logic          ext_tx_clk_i,
	input  wire logic          ext_rx_clk_i,
	input  wire logic          dev_cts_i,
	// Serial core side
	output spdc_mode_type      mode_o,
	output logic [7:0]         cmd_o,
	output spdc_link_type      link_o
);
	typedef logic [31:0] cnt_t;

	// Half period of a rate clock at factor 1 timing base
	function automatic cnt_t half_div(input logic [3:0] pos);
		int unsigned bps;
		bps = 75;
		case (pos)
			4'h1: bps = 9600;
			4'h2: bps = 4800;
			4'h3: bps = 2400;
			4'h4: bps = 1800;
			4'h5: bps = 1200;
			4'h6: bps = 600;
			4'h7: bps = 300;
			4'h8: bps = 150;
			4'h9: bps = 110;
			default: bps = 75;
		endcase
		return cnt_t'(CLK_HZ / (2 * bps));
	endfunction : half_div

	spdc_state_type state_r;
	spdc_mode_type  mode_r;
	logic [7:0]     cmd_r;
	logic [7:0]     ctrl_r;
	logic [7:0]     sw_r;
	spdc_sw_type    cfg_r;
	logic           ph_wr_r;
	logic [7:0]     ph_addr_r;
	cnt_t           div_cnt_r;
	logic           rate_clk_r;
	spdc_link_type  link_r;
	logic [31:0]    rdata_r;

	logic access;
	logic iresel;
	assign access = hsel_i && hready_i && htrans_i == `SPDC_HTRANS_NONSEQ;
	assign iresel = ph_wr_r && ph_addr_r == `SPDC_ADDR_CTRL
		&& hwdata_i[`SPDC_CTRL_IRESET];

	// Reset sequencing; switches follow the pins while reset holds and ce_i is high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= SPDC_IN_RESET;
		end else if (ce_i) begin
			case (state_r)
				SPDC_IN_RESET: state_r <= SPDC_RUN;
				SPDC_RUN: state_r <= iresel ? SPDC_IRESET : SPDC_RUN;
				SPDC_IRESET: state_r <= SPDC_RUN;
				default: state_r <= SPDC_IN_RESET;
			endcase
		end
	end

	// Switch capture is clocked, never a reset value; an interface reset
	// samples on the edge before the reload, so the reload sees fresh ones
	always_ff @(posedge clk_i) begin
		if (ce_i && (rst_i || (state_r == SPDC_RUN && iresel))) begin
			sw_r  <= mode_sw_i;
			cfg_r <= cfg_sw_i;
		end
	end

	// Address phase capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_wr_r   <= 1'b0;
			ph_addr_r <= 8'h00;
		end else if (ce_i && hready_i) begin
			ph_wr_r   <= access && hwrite_i;
			ph_addr_r <= haddr_i[7:0];
		end
	end

	// Mode word: switch default after any reset, host write overrides
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= spdc_mode_type'(`SPDC_DEF_MODE);
		end else if (ce_i) begin
			if (state_r == SPDC_IN_RESET || state_r == SPDC_IRESET)
				mode_r <= spdc_mode_type'(sw_r);
			else if (ph_wr_r && ph_addr_r == `SPDC_ADDR_MODE)
				mode_r <= spdc_mode_type'(hwdata_i[7:0]);
		end
	end

	// Command and control words; whole byte replaced on write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_r  <= `SPDC_CMD_RESET;
			ctrl_r <= 8'h00;
		end else if (ce_i) begin
			if (state_r == SPDC_IRESET) begin
				cmd_r  <= `SPDC_CMD_RESET;
				ctrl_r <= 8'h00;
			end else if (ph_wr_r && ph_addr_r == `SPDC_ADDR_CMD) begin
				cmd_r <= hwdata_i[7:0];
			end else if (ph_wr_r && ph_addr_r == `SPDC_ADDR_CTRL) begin
				// Reset bit self-clears during the interface reset
				ctrl_r <= hwdata_i[7:0];
			end
		end
	end

	// Internal bit rate clock from the rate selector
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt_r  <= '0;
			rate_clk_r <= 1'b0;
		end else if (ce_i) begin
			if (div_cnt_r + 1 >= half_div(cfg_r.rate_pos)) begin
				div_cnt_r  <= '0;
				rate_clk_r <= ~rate_clk_r;
			end else begin
				div_cnt_r <= div_cnt_r + 1;
			end
		end
	end

	// Clock, clear-to-send and line selection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_r <= '0;
		end else if (ce_i) begin
			// The core relies on software avoiding a zero factor
			link_r.tx_clk <= cfg_r.ext_tx_clk ? ext_tx_clk_i
				: rate_clk_r;
			link_r.rx_clk <= cfg_r.ext_rx_clk ? ext_rx_clk_i
				: rate_clk_r;
			link_r.cts    <= cfg_r.cts_dev ? dev_cts_i : 1'b1;
			link_r.rts_en <= ~cfg_r.cur_loop;
			link_r.sel_ok <= cfg_r.sel_code >= `SPDC_SEL_MIN;
		end
	end

	// Read data, registered for the data phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= 32'h0;
		end else if (ce_i && access && !hwrite_i) begin
			case (haddr_i[7:0])
				`SPDC_ADDR_MODE:   rdata_r <= {24'h0, mode_r};
				`SPDC_ADDR_CMD:    rdata_r <= {24'h0, cmd_r};
				`SPDC_ADDR_CTRL:   rdata_r <= {24'h0, ctrl_r};
				`SPDC_ADDR_SWITCH: rdata_r <= {24'h0, sw_r};
				`SPDC_ADDR_STATUS: rdata_r <= {24'h0, cfg_r.sel_code,
					1'b0, state_r};
				default:           rdata_r <= 32'h0;
			endcase
		end
	end

	assign hrdata_o    = rdata_r;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign mode_o      = mode_r;
	assign cmd_o       = cmd_r;
	assign link_o      = link_r;

	// Assertions; each except a_rd_upper checks the registered result one edge later
	a_mode_load: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && state_r == SPDC_IN_RESET |=> mode_r == $past(sw_r))
		else $error("mode not loaded from switches");
	a_mode_reload: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && state_r == SPDC_IRESET |=> mode_r == $past(sw_r))
		else $error("mode not reloaded on interface reset");
	a_sw_capture: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && state_r == SPDC_RUN && iresel
		|=> sw_r == $past(mode_sw_i))
		else $error("switches not sampled before reload");
	a_mode_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && state_r == SPDC_RUN && ph_wr_r
		&& ph_addr_r == `SPDC_ADDR_MODE
		|=> mode_r == $past(hwdata_i[7:0]))
		else $error("host mode write lost");
	a_mode_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && state_r == SPDC_RUN
		&& !(ph_wr_r && ph_addr_r == `SPDC_ADDR_MODE)
		|=> $stable(mode_r))
		else $error("mode changed without a write");
	a_ce_freeze: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!ce_i |=> $stable(mode_r) && $stable(cmd_r)
		&& $stable(ctrl_r) && $stable(state_r))
		else $error("state moved while enable low");
	a_cmd_reset: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && state_r == SPDC_IRESET
		|=> cmd_r == `SPDC_CMD_RESET && ctrl_r == 8'h00)
		else $error("command word not reset");
	a_cmd_full: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && state_r == SPDC_RUN && ph_wr_r
		&& ph_addr_r == `SPDC_ADDR_CMD
		|=> cmd_r == $past(hwdata_i[7:0]))
		else $error("command write not whole");
	a_ctrl_full: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && state_r == SPDC_RUN && ph_wr_r
		&& ph_addr_r == `SPDC_ADDR_CTRL
		|=> ctrl_r == $past(hwdata_i[7:0]))
		else $error("control write not whole");
	a_rd_upper: assert property (
		@(posedge clk_i) disable iff (rst_i)
		hrdata_o[31:8] == 24'h0)
		else $error("read data wider than a byte");
	a_mode_read: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && access && !hwrite_i && haddr_i[7:0] == `SPDC_ADDR_MODE
		|=> hrdata_o[7:0] == $past(mode_r))
		else $error("mode word read wrong");
	a_sw_read: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && access && !hwrite_i && haddr_i[7:0] == `SPDC_ADDR_SWITCH
		|=> hrdata_o[7:0] == $past(sw_r))
		else $error("switch word read wrong");
	a_status_rd: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && access && !hwrite_i && haddr_i[7:0] == `SPDC_ADDR_STATUS
		|=> hrdata_o[7:4] == $past(cfg_r.sel_code))
		else $error("select code not readable");
	a_cts_high: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !cfg_r.cts_dev |=> link_r.cts)
		else $error("cts not forced high");
	a_cts_follow: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && cfg_r.cts_dev |=> link_r.cts == $past(dev_cts_i))
		else $error("cts not following device");
	a_loop_rts: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && cfg_r.cur_loop |=> !link_r.rts_en)
		else $error("controls live in current loop");
	a_rts_live: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !cfg_r.cur_loop |=> link_r.rts_en)
		else $error("controls missing in line mode");
	a_sel_range: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && cfg_r.sel_code < `SPDC_SEL_MIN |=> !link_r.sel_ok)
		else $error("reserved select code accepted");
	a_sel_valid: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && cfg_r.sel_code >= `SPDC_SEL_MIN |=> link_r.sel_ok)
		else $error("valid select code refused");
	a_ireset_seq: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && state_r == SPDC_RUN && iresel
		|=> state_r == SPDC_IRESET ##1 state_r == SPDC_RUN)
		else $error("interface reset sequence broken");
	a_tx_clk_sel: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !cfg_r.ext_tx_clk |=> link_r.tx_clk == $past(rate_clk_r))
		else $error("internal tx clock not used");
	a_rx_clk_sel: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !cfg_r.ext_rx_clk |=> link_r.rx_clk == $past(rate_clk_r))
		else $error("internal rx clock not used");
	a_tx_clk_ext: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && cfg_r.ext_tx_clk |=> link_r.tx_clk == $past(ext_tx_clk_i))
		else $error("cable tx clock not used");
	a_rx_clk_ext: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && cfg_r.ext_rx_clk |=> link_r.rx_clk == $past(ext_rx_clk_i))
		else $error("cable rx clock not used");

	c_host_mode: cover property (@(posedge clk_i)
		ph_wr_r && ph_addr_r == `SPDC_ADDR_MODE);
	c_ireset: cover property (@(posedge clk_i) state_r == SPDC_IRESET);
	c_rate_tick: cover property (@(posedge clk_i) $rose(rate_clk_r));
	c_cur_loop: cover property (@(posedge clk_i)
		cfg_r.cur_loop && !link_r.rts_en);
	c_ext_clk: cover property (@(posedge clk_i)
		cfg_r.ext_tx_clk && cfg_r.ext_rx_clk);
endmodule : spdc_top

// ==== testbench/spdc_term_model.sv ====
// Terminal side model: cable clocks and clear-to-send.
// Assumes the bench clock; cable clocks run free, as a modem's would.
module spdc_term_model (
	// Bench clock and command
	input  wire logic clk_i,
	input  wire logic cts_cmd_i,
	// Cable outputs
	output logic      ext_tx_clk_o,
	output logic      ext_rx_clk_o,
	output logic      dev_cts_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial begin
		ext_tx_clk_o = 1'b0;
		ext_rx_clk_o = 1'b0;
		dev_cts_o = 1'b0;
	end
	// Equal high and low spans keep the duty at one half
	always @(posedge clk_i) begin
		cnt <= cnt + 1;
		if (cnt % 3 == 2) ext_tx_clk_o <= ~ext_tx_clk_o;
		if (cnt % 4 == 3) ext_rx_clk_o <= ~ext_rx_clk_o;
		dev_cts_o <= cts_cmd_i;
	end
endmodule : spdc_term_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the default configuration block.
// Assumes spdc_pkg is compiled first and spdc_params.svh is included.
`include "spdc_params.svh"
module tb_top import spdc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// Small clock figure keeps rate periods short
	localparam int CLK = 96000;
	logic          clk_i = 1'b0;
	logic          rst_i = 1'b1;
	logic          hsel = 1'b0;
	logic [31:0]   haddr = 32'h0;
	logic [1:0]    htrans = 2'h0;
	logic          hwrite = 1'b0;
	logic [2:0]    hsize = 3'h0;
	logic [31:0]   hwdata = 32'h0;
	logic [31:0]   hrdata;
	logic          hready;
	logic          hresp;
	logic [7:0]    mode_sw = 8'h5D;
	spdc_sw_type   cfg_sw = {4'h0, 4'h7, 4'hA};
	logic          cts_cmd = 1'b0;
	logic          ce = 1'b1;
	logic          txc, rxc, dcts;
	spdc_mode_type mode;
	logic [7:0]    cmd;
	spdc_link_type link;
	logic [31:0]   rd;
	int            error_cnt = 0;
	int            cmp_count = 0;
	int            bps[10] = '{75, 9600, 4800, 2400, 1800, 1200, 600, 300,
		150, 110};

	always #5 clk_i = ~clk_i;

	spdc_top #(.CLK_HZ(CLK)) u_spdc_top (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(hresp), .mode_sw_i(mode_sw), .cfg_sw_i(cfg_sw),
		.ext_tx_clk_i(txc), .ext_rx_clk_i(rxc), .dev_cts_i(dcts),
		.mode_o(mode), .cmd_o(cmd), .link_o(link));
	spdc_term_model u_spdc_term_model (.clk_i(clk_i), .cts_cmd_i(cts_cmd),
		.ext_tx_clk_o(txc), .ext_rx_clk_o(rxc), .dev_cts_o(dcts));

	task automatic check(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict

	// Only the watchdog ends a slave that never answers
	task automatic wait_rdy;
		do @(posedge clk_i); while (hready !== 1'b1);
	endtask : wait_rdy

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= `SPDC_HTRANS_NONSEQ;
		hsize <= `SPDC_HSIZE_WORD;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		check("hresp", 32'(hresp), 32'h0);
	endtask : bus

	task automatic rdck(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(nm, rd, exp);
	endtask : rdck

	// Switches, the mode word ones included, are taken only at a reset
	task automatic ireset;
		bus(1'b1, `SPDC_ADDR_CTRL, 32'h20);
		repeat (2) @(posedge clk_i);
	endtask : ireset

	// Upper word bits are junk on purpose; factor bits never both zero
	task automatic t_modes;
		logic [7:0] v[4] = '{8'h41, 8'h9E, 8'hF7, 8'h2A};
		bus(1'b1, `SPDC_ADDR_SWITCH, 32'h0);
		rdck("switch", `SPDC_ADDR_SWITCH, 32'(mode_sw));
		rdck("unmapped", 8'h20, 32'h0);
		foreach (v[i]) begin
			bus(1'b1, `SPDC_ADDR_MODE, {24'hFFFFFF, v[i]});
			rdck("mode_rd", `SPDC_ADDR_MODE, 32'(v[i]));
			check("mode", 32'(mode), 32'(v[i]));
			check("stop", 32'(mode.stop_bits), 32'(v[i][7:6]));
			check("par", 32'(mode[5:4]), 32'(v[i][5:4]));
			check("len", 32'(mode.char_len), 32'(v[i][3:2]));
			check("fact", 32'(mode.rate_factor), 32'(v[i][1:0]));
		end
	endtask : t_modes

	task automatic t_ireset;
		mode_sw <= 8'hB6;
		bus(1'b1, `SPDC_ADDR_CMD, 32'h37);
		rdck("cmd_wr", `SPDC_ADDR_CMD, 32'h37);
		check("cmd_o", 32'(cmd), 32'h37);
		ireset();
		rdck("ctrl", `SPDC_ADDR_CTRL, 32'h0);
		rdck("cmd_rd", `SPDC_ADDR_CMD, 32'h5);
		check("cmd_rl", 32'(cmd), 32'h5);
		check("mode_rl", 32'(mode), 32'hB6);
		rdck("switch_rl", `SPDC_ADDR_SWITCH, 32'hB6);
	endtask : t_ireset

	// A write while the enable is low must leave the mode word alone
	task automatic t_freeze;
		ce <= 1'b0;
		bus(1'b1, `SPDC_ADDR_MODE, 32'h55);
		ce <= 1'b1;
		rdck("mode_frz", `SPDC_ADDR_MODE, 32'hB6);
	endtask : t_freeze

	task automatic t_link;
		int c[4] = '{0, 1, 2, 15};
		for (int i = 0; i < 4; i++) begin
			cfg_sw.cts_dev <= i[0];
			cts_cmd <= i[1];
			cfg_sw.sel_code <= 4'(c[i]);
			cfg_sw.cur_loop <= i[0];
			ireset();
			repeat (2) @(posedge clk_i);
			check("cts", 32'(link.cts), 32'(i[0] ? i[1] : 1));
			check("sel", 32'(link.sel_ok), 32'(c[i] >= 2));
			check("rts", 32'(link.rts_en), 32'(!i[0]));
			rdck("status", `SPDC_ADDR_STATUS, {24'h0, 4'(c[i]), 4'h2});
		end
	endtask : t_link

	task automatic half(output int n);
		logic l;
		for (int k = 0; k < 2; k++) begin
			l = link.tx_clk;
			n = 0;
			while (link.tx_clk === l && n < 2000) begin
				@(posedge clk_i);
				n++;
			end
		end
	endtask : half

	task automatic t_clk;
		int n, e, nt, nr;
		logic pt, pr;
		for (int p = 0; p < 10; p++) begin
			cfg_sw.rate_pos <= 4'(p);
			ireset();
			half(n);
			half(n);
			e = CLK / (2 * bps[p]);
			check("half", 32'(n >= e - 1 && n <= e + 1), 32'h1);
		end
		cfg_sw.ext_tx_clk <= 1'b1;
		cfg_sw.ext_rx_clk <= 1'b1;
		ireset();
		repeat (8) @(posedge clk_i);
		{nt, nr, pt, pr} = {32'h0, 32'h0, link.tx_clk, link.rx_clk};
		repeat (120) begin
			@(posedge clk_i);
			nt += int'(link.tx_clk !== pt);
			nr += int'(link.rx_clk !== pr);
			{pt, pr} = {link.tx_clk, link.rx_clk};
		end
		check("ext_tx", 32'(nt >= 39 && nt <= 41), 32'h1);
		check("ext_rx", 32'(nr >= 29 && nr <= 31), 32'h1);
	endtask : t_clk

	initial begin
		repeat (16) @(posedge clk_i);
		check("mode_in_rst", 32'(mode), 32'(`SPDC_DEF_MODE));
		check("cmd_in_rst", 32'(cmd), 32'h5);
		check("link_in_rst", 32'(link), 32'h0);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1 check("mode_first", 32'(mode), 32'h5D);
		@(posedge clk_i);
		t_modes();
		t_ireset();
		t_link();
		t_clk();
		t_freeze();
		give_verdict();
	end

	initial begin
		repeat (40000) @(posedge clk_i);
		error_cnt++;
		give_verdict();
	end
endmodule : tb_top
